/* File: shared/cbr_pkg.sv */
/*
 * Package for the card bus request block: line counts, reset values,
 * timing constants and the carrier structs shared by the design files.
 * Assumes a single 10 MHz clock domain.
 */
package cbr_pkg;

    localparam int CBR_IRQ_LINES = 15;
    localparam int CBR_DMA_CHANS = 4;
    localparam int CBR_IRQ_IDX_W = 4;
    localparam int CBR_DMA_IDX_W = 2;

    // Channel users are fixed.
    localparam logic [1:0] CBR_CH_DISPLAY = 2'h0;
    localparam logic [1:0] CBR_CH_DISK = 2'h1;
    localparam logic [1:0] CBR_CH_GRAPHICS = 2'h2;
    localparam logic [1:0] CBR_CH_AUX = 2'h3;

    // Bus timing reference and the local clock.
    localparam real CBR_BUS_CLK_MHZ = 4.9152;
    localparam real CBR_CLK_MHZ = 10.0;
    localparam int CBR_SYNC_STAGES = 2;

    // Reset values of the line drivers.
    localparam logic CBR_POWER_OFF_RST = 1'h0;
    localparam logic [3:0] CBR_GRANT_RST = 4'h0;
    localparam logic [14:0] CBR_IRQ_IDLE_N = 15'h7FFF;

    typedef struct packed {
        logic [CBR_IRQ_LINES-1:0] interrupt_request_lines_n;
        logic [CBR_DMA_CHANS-1:0] dma_service_request;
    } cbr_card_req_t;

    typedef struct packed {
        logic valid;
        logic [CBR_IRQ_IDX_W-1:0] line;
    } cbr_irq_out_t;

    typedef struct packed {
        logic [CBR_DMA_CHANS-1:0] dma_grant;
        logic final_count_pulse;
        logic [CBR_DMA_IDX_W-1:0] active_chan;
    } cbr_dma_out_t;

endpackage

/* File: design/cbr_sync.sv */
/*
 * Two-flop synchroniser for a vector of request lines.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module cbr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // The first stage feeds only the second one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

/* File: design/cbr_request_lines.sv */
/*
 * Request and acknowledge logic for the card-cage bus: interrupt request
 * prioritisation, DMA grant handling and the power-off command line.
 * Assumes cards drive requests asynchronously and that the board-side
 * controllers supply acknowledge, transfer-done and power-off commands
 * synchronous to clk.
 */
// What this block does
// [R1] Power-off line high commands supply off
// [R2] Fifteen active-low interrupt request lines from cards
// [R3] Card holds interrupt until processor acknowledges
// [R4] Line zero highest priority, last lowest
// [R5] Card holds DMA request until grant
// [R6] Channels: display, disk, graphics, auxiliary
// [R7] Grant line driven high on acceptance
// [R8] Timing referred to the system clock
// [R9] One-clock high pulse at terminal count
// [R10] Synchronise all incoming request lines first
`timescale 1ns/100ps
`default_nettype none
module cbr_request_lines
    import cbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire cbr_card_req_t card_req,
    input wire logic irq_ack,
    input wire logic dma_enable,
    input wire logic dma_done,
    input wire logic power_off_req,
    output logic power_off_command,
    output cbr_irq_out_t irq_out,
    output cbr_dma_out_t dma_out
);
    typedef enum logic [1:0] {
        CBR_DMA_IDLE,
        CBR_DMA_GRANT,
        CBR_DMA_FINISH
    } cbr_dma_state_t;

    logic [CBR_IRQ_LINES-1:0] irq_n_sync;
    logic [CBR_DMA_CHANS-1:0] drq_sync;

    // [R10] synchronise card lines
    cbr_sync #(
        .WIDTH(CBR_IRQ_LINES),
        .RST_VAL(CBR_IRQ_IDLE_N)
    ) u_irq_sync (
        .clk(clk),
        .rst(rst),
        .d(card_req.interrupt_request_lines_n),
        .q(irq_n_sync)
    );

    // [R10] synchronise DMA requests
    cbr_sync #(
        .WIDTH(CBR_DMA_CHANS),
        .RST_VAL(CBR_GRANT_RST)
    ) u_drq_sync (
        .clk(clk),
        .rst(rst),
        .d(card_req.dma_service_request),
        .q(drq_sync)
    );

    // [R2] requests are active low
    wire [CBR_IRQ_LINES-1:0] irq_pending = ~irq_n_sync;

    // [R4] lowest index wins
    logic [CBR_IRQ_IDX_W-1:0] irq_win;
    always_comb begin
        irq_win = '0;
        for (int i = CBR_IRQ_LINES - 1; i >= 0; i--) begin
            if (irq_pending[i]) begin
                irq_win = CBR_IRQ_IDX_W'(i);
            end
        end
    end
    wire irq_any = |irq_pending;

    // The chosen line is frozen while presented so the processor's
    // acknowledge always refers to the line it saw; a card keeps its
    // line low until then, so nothing is lost.
    logic irq_valid_r;
    logic [CBR_IRQ_IDX_W-1:0] irq_line_r;
    logic irq_valid_nxt;
    logic [CBR_IRQ_IDX_W-1:0] irq_line_nxt;

    // After an acknowledge the card releases its line at once, but the
    // synchroniser still shows it low for CBR_SYNC_STAGES more edges. The
    // quiet count keeps that stale level from coming back as a phantom
    // interrupt; the price is three idle cycles between interrupts.
    logic [1:0] irq_quiet_r;
    logic [1:0] irq_quiet_nxt;
    wire irq_taken = irq_valid_r & irq_ack;
    wire irq_quiet = |irq_quiet_r;

    // [R3] hold until acknowledge
    assign irq_valid_nxt = irq_valid_r ? ~irq_ack : (irq_any & ~irq_quiet);
    assign irq_line_nxt = irq_valid_r ? irq_line_r : irq_win;
    assign irq_quiet_nxt = irq_taken ? 2'(CBR_SYNC_STAGES) : (irq_quiet ? irq_quiet_r - 2'h1 : irq_quiet_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_valid_r <= 1'h0;
            irq_line_r <= '0;
            irq_quiet_r <= '0;
        end else begin
            irq_valid_r <= irq_valid_nxt;
            irq_line_r <= irq_line_nxt;
            irq_quiet_r <= irq_quiet_nxt;
        end
    end

    // DMA arbitration: fixed priority, channel 0 (display) highest, as
    // refresh of the screen cannot wait behind disk transfers.
    // [R6] fixed channel users
    logic [CBR_DMA_IDX_W-1:0] dma_win;
    always_comb begin
        dma_win = CBR_CH_AUX;
        if (drq_sync[CBR_CH_GRAPHICS]) begin
            dma_win = CBR_CH_GRAPHICS;
        end
        if (drq_sync[CBR_CH_DISK]) begin
            dma_win = CBR_CH_DISK;
        end
        if (drq_sync[CBR_CH_DISPLAY]) begin
            dma_win = CBR_CH_DISPLAY;
        end
    end
    wire dma_any = |drq_sync;

    cbr_dma_state_t state_r;
    cbr_dma_state_t state_nxt;
    logic [CBR_DMA_IDX_W-1:0] chan_r;
    logic [CBR_DMA_IDX_W-1:0] chan_nxt;
    logic [CBR_DMA_CHANS-1:0] grant_r;
    logic [CBR_DMA_CHANS-1:0] grant_nxt;
    logic tc_r;
    logic tc_nxt;

    // A card drops its request on seeing the grant, yet the synchroniser
    // keeps showing it for CBR_SYNC_STAGES more edges. Without this quiet
    // count the released channel would be granted a second time at once.
    logic [1:0] dma_quiet_r;
    logic [1:0] dma_quiet_nxt;
    wire dma_quiet = |dma_quiet_r;
    wire dma_release = (state_r == CBR_DMA_FINISH);
    assign dma_quiet_nxt = dma_release ? 2'(CBR_SYNC_STAGES) : (dma_quiet ? dma_quiet_r - 2'h1 : dma_quiet_r);

    always_comb begin
        state_nxt = state_r;
        chan_nxt = chan_r;
        grant_nxt = grant_r;
        tc_nxt = 1'h0;
        unique case (state_r)
            CBR_DMA_IDLE: begin
                // A request seen inside the quiet window may be stale, so
                // nothing is granted until the window has passed.
                if (dma_enable && dma_any && !dma_quiet) begin
                    chan_nxt = dma_win;
                    // [R7] grant driven high
                    grant_nxt = CBR_DMA_CHANS'(1) << dma_win;
                    state_nxt = CBR_DMA_GRANT;
                end
            end
            CBR_DMA_GRANT: begin
                if (dma_done) begin
                    // [R9] one-clock terminal pulse
                    tc_nxt = 1'h1;
                    state_nxt = CBR_DMA_FINISH;
                end
            end
            CBR_DMA_FINISH: begin
                // Grant drops together with the end of the pulse.
                grant_nxt = CBR_GRANT_RST;
                state_nxt = CBR_DMA_IDLE;
            end
            // The fourth code is unused; a corrupted state returns to idle.
            default: begin
                state_nxt = CBR_DMA_IDLE;
            end
        endcase
    end

    // [R8] all timing on clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= CBR_DMA_IDLE;
            chan_r <= '0;
            grant_r <= CBR_GRANT_RST;
            tc_r <= 1'h0;
            dma_quiet_r <= '0;
        end else begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
            grant_r <= grant_nxt;
            tc_r <= tc_nxt;
            dma_quiet_r <= dma_quiet_nxt;
        end
    end

    // [R1] power-off command
    logic power_off_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_off_r <= CBR_POWER_OFF_RST;
        end else begin
            power_off_r <= power_off_req;
        end
    end

    // Every output leaves straight from a register, so cards see no glitches.
    assign power_off_command = power_off_r;
    assign irq_out.valid = irq_valid_r;
    assign irq_out.line = irq_line_r;
    assign dma_out.dma_grant = grant_r;
    assign dma_out.final_count_pulse = tc_r;
    assign dma_out.active_chan = chan_r;
endmodule
`default_nettype wire

/* File: tb/cbr_request_lines_monitor.sv */
/* Checker for the card bus request block.
   Assumes it is bound to the block's top ports. */
`timescale 1ns/100ps
`default_nettype none
module cbr_request_lines_monitor
    import cbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire cbr_card_req_t card_req,
    input wire logic irq_ack,
    input wire logic dma_enable,
    input wire logic dma_done,
    input wire logic power_off_req,
    input wire logic power_off_command,
    input wire cbr_irq_out_t irq_out,
    input wire cbr_dma_out_t dma_out
);
    logic [14:0] i1_r, i2_r;
    logic [3:0] d1_r, d2_r;
    wire logic [3:0] g = dma_out.dma_grant;
    function automatic logic [3:0] lo(input logic [14:0] v);
        lo = 4'hF;
        for (int i = 14; i >= 0; i--) if (v[i]) lo = i[3:0];
    endfunction
    // Shadow of the input synchronisers, so decisions can be traced to their cause.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {i2_r, i1_r} <= {2{15'h7FFF}};
            {d2_r, d1_r} <= 8'h00;
        end else begin
            {i2_r, i1_r} <= {i1_r, card_req.interrupt_request_lines_n};
            {d2_r, d1_r} <= {d1_r, card_req.dma_service_request};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tc_high;
        dma_out.final_count_pulse && |g;
    endsequence
    sequence s_tc;
        s_tc_high ##1 !dma_out.final_count_pulse;
    endsequence
    sequence s_irq_quiet;
        (!irq_out.valid) [*3];
    endsequence
    sequence s_grant_quiet;
        (!(|g)) [*3];
    endsequence
    property p_power; power_off_command == $past(power_off_req); endproperty
    a_power: assert property (p_power) else $error("power off mismatch");
    property p_irq_sync; $rose(irq_out.valid) |-> !$past(&i2_r); endproperty
    a_irq_sync: assert property (p_irq_sync) else $error("irq not synchronised");
    property p_irq_prio; $rose(irq_out.valid) |-> irq_out.line == $past(lo(~i2_r)); endproperty
    a_irq_prio: assert property (p_irq_prio) else $error("irq priority wrong");
    property p_irq_hold; irq_out.valid && !irq_ack |=> irq_out.valid && $stable(irq_out.line); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
    property p_irq_drop; irq_out.valid && irq_ack |=> !irq_out.valid; endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq kept after ack");
    property p_irq_quiet; irq_out.valid && irq_ack |=> s_irq_quiet; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("acknowledged irq shown again");
    property p_grant; |g |-> $onehot(g) && g[dma_out.active_chan]; endproperty
    a_grant: assert property (p_grant) else $error("grant not one-hot");
    property p_chan; $rose(|g) |-> $past(dma_enable) && {2'h0, dma_out.active_chan} == $past(lo({11'h0, d2_r}));
    endproperty
    a_chan: assert property (p_chan) else $error("grant channel wrong");
    property p_grant_quiet; $fell(|g) |-> s_grant_quiet; endproperty
    a_grant_quiet: assert property (p_grant_quiet) else $error("released channel granted again");
    property p_tc; dma_out.final_count_pulse |-> s_tc; endproperty
    a_tc: assert property (p_tc) else $error("terminal pulse wrong");
endmodule
`default_nettype wire

/* File: tb/cbr_card_model.sv */
/* Expansion cards: hold requests until served.
   Assumes raise inputs change just after a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module cbr_card_model
    import cbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [14:0] irq_raise,
    input wire logic [3:0] drq_raise,
    input wire cbr_irq_out_t irq_out,
    input wire logic irq_ack,
    input wire logic [3:0] dma_grant,
    output cbr_card_req_t card_req
);
    logic [14:0] irq_r;
    logic [3:0] drq_r;
    wire logic [14:0] acked = (irq_out.valid && irq_ack) ? 15'h1 << irq_out.line : 15'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 15'h0;
            drq_r <= 4'h0;
        end else begin
            irq_r <= (irq_r | irq_raise) & ~acked;
            drq_r <= (drq_r | drq_raise) & ~dma_grant;
        end
    end
    assign card_req = {~irq_r, drq_r};
endmodule
`default_nettype wire

/* File: tb/tb_cbr_request_lines.sv */
/* Testbench for the card bus request block.
   Assumes the card model stands on the far side. */
`timescale 1ns/100ps
`default_nettype none
module tb_cbr_request_lines
    import cbr_pkg::*;
;
    logic clk = 0, rst = 1, irq_ack = 0, dma_enable = 0, dma_done = 0, power_off_req = 0, power_off_command;
    logic [14:0] irq_raise = 15'h0, pend;
    logic [3:0] drq_raise = 4'h0, dp;
    logic [31:0] seed = 32'h3B24AB63;
    int n_fail = 0, samples_checked = 0, k;
    cbr_card_req_t card_req;
    cbr_irq_out_t irq_out;
    cbr_dma_out_t dma_out;
    always #50 clk = ~clk;
    cbr_card_model cards(.clk(clk), .rst(rst), .irq_raise(irq_raise), .drq_raise(drq_raise), .irq_out(irq_out),
        .irq_ack(irq_ack), .dma_grant(dma_out.dma_grant), .card_req(card_req));
    cbr_request_lines DUT(.clk(clk), .rst(rst), .card_req(card_req), .irq_ack(irq_ack), .dma_enable(dma_enable),
        .dma_done(dma_done), .power_off_req(power_off_req), .power_off_command(power_off_command),
        .irq_out(irq_out), .dma_out(dma_out));
    function automatic logic [3:0] lo(input logic [14:0] v);
        lo = 4'hF;
        for (int i = 14; i >= 0; i--) if (v[i]) lo = i[3:0];
    endfunction
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h got %h", what, exp, got);
        end
    endtask
    task step;
        @(posedge clk);
        #10;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    task results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        #10 rst = 0;
        repeat (20) begin
            seed = xorshift(seed);
            power_off_req = seed[0];
            step();
            chk("power_off", {7'h0, power_off_req}, {7'h0, power_off_command});
        end
        for (int r = 0; r < 6; r++) begin
            seed = xorshift(seed);
            pend = (r == 0) ? 15'h7FFF : seed[14:0] | 15'h4000;
            irq_raise = pend;
            step();
            irq_raise = 15'h0;
            while (pend != 15'h0) begin
                for (k = 0; k < 20 && irq_out.valid !== 1'b1; k++) step();
                chk("irq_valid", 8'h1, {7'h0, irq_out.valid});
                chk("irq_line", {4'h0, lo(pend)}, {4'h0, irq_out.line});
                irq_ack = 1;
                step();
                irq_ack = 0;
                chk("irq_dropped", 8'h0, {7'h0, irq_out.valid});
                pend &= ~(15'h1 << lo(pend));
                step();
            end
        end
        for (int r = 0; r < 6; r++) begin
            seed = xorshift(seed);
            dp = (r == 0) ? 4'hF : seed[3:0] | 4'h8;
            drq_raise = dp;
            step();
            drq_raise = 4'h0;
            if (r == 0) begin
                repeat (6) step();
                chk("grant_off", 8'h0, {4'h0, dma_out.dma_grant});
                dma_enable = 1;
            end
            while (dp != 4'h0) begin
                for (k = 0; k < 20 && dma_out.dma_grant === 4'h0; k++) step();
                chk("grant", 8'h1 << lo({11'h0, dp}), {4'h0, dma_out.dma_grant});
                chk("active_chan", {4'h0, lo({11'h0, dp})}, {6'h0, dma_out.active_chan});
                dma_done = 1;
                step();
                dma_done = 0;
                for (k = 0; k < 3 && dma_out.final_count_pulse !== 1'b1; k++) step();
                chk("final_count", 8'h1, {7'h0, dma_out.final_count_pulse});
                step();
                chk("final_count_end", 8'h0, {7'h0, dma_out.final_count_pulse});
                dp &= ~(4'h1 << lo({11'h0, dp}));
                repeat (2) step();
            end
        end
        results();
    end
endmodule
bind cbr_request_lines cbr_request_lines_monitor mon(.clk(clk), .rst(rst), .card_req(card_req), .irq_ack(irq_ack),
    .dma_enable(dma_enable), .dma_done(dma_done), .power_off_req(power_off_req),
    .power_off_command(power_off_command), .irq_out(irq_out), .dma_out(dma_out));
`default_nettype wire
